// ==== hw/otlvc_pkg.sv ====
package otlvc_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_DEF_A0    = 8'h30;
    localparam logic [7:0] OFS_DEF_A1    = 8'h31;
    localparam logic [7:0] OFS_DEF_A2    = 8'h32;
    localparam logic [7:0] OFS_REVISION  = 8'h3F;
    localparam logic [7:0] OFS_CONFIG1   = 8'h40;
    localparam logic [7:0] OFS_STATUS    = 8'h42;
    localparam logic [7:0] OFS_DEF_B0    = 8'h5C;
    localparam logic [7:0] OFS_DEF_B1    = 8'h5D;
    localparam logic [7:0] OFS_DEF_B2    = 8'h5E;
    localparam logic [7:0] OFS_LIMIT_R1  = 8'h6A;
    localparam logic [7:0] OFS_LIMIT_R2  = 8'h6B;
    localparam logic [7:0] OFS_CONFIG3   = 8'h7C;
    localparam logic [7:0] OFS_CONFIG4   = 8'h7D;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_LATCH_RESET = 7;
    localparam int BIT_LOCK        = 1;
    localparam int BIT_LATCHED     = 0;
    localparam int BIT_HYST_EN     = 4;
    localparam int BIT_TO_DIS      = 0;
    localparam int BIT_LATCH_SRC   = 4;
    localparam int BIT_PIN5_FAN    = 5;
    localparam int BIT_PIN9_LO     = 0;
    localparam int BIT_PIN9_HI     = 1;

    // ****************************************************************
    // Reset values per variant
    // ****************************************************************
    localparam logic [7:0] RST_DEF_A_BASE  = 8'h00;
    localparam logic [7:0] RST_DEF_A_LATCH = 8'hFF;
    localparam logic [7:0] RST_DEF_B_BASE  = 8'h82;
    localparam logic [7:0] RST_DEF_B_LATCH = 8'h62;
    localparam logic [7:0] RST_LIM_R2_BASE  = 8'h64; // 100 C
    localparam logic [7:0] RST_LIM_R2_LATCH = 8'h88; // 136 C
    localparam logic [7:0] RST_LIM_R1      = 8'h64;
    localparam logic [7:0] RST_CONFIG      = 8'h00;
    localparam logic [7:0] HYST_DEGREES    = 8'h04;
    // Revision codes: arbitrary values
    localparam logic [7:0] REV_BASE  = 8'h11;
    localparam logic [7:0] REV_LATCH = 8'h12;

    // ****************************************************************
    // Bus addresses and timing
    // ****************************************************************
    localparam logic [6:0] ADDR_FIXED = 7'h2E;
    localparam logic [6:0] ADDR_SEL0  = 7'h2C;
    localparam logic [6:0] ADDR_SEL1  = 7'h2D;
    localparam logic [1:0] PIN9_ALERT = 2'h3;
    localparam logic [1:0] PIN9_THERM = 2'h2;
    localparam logic [3:0] BITS_BYTE  = 4'h8;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam int CLK_PERIOD_PS   = 4000;
    localparam longint TIMEOUT_MIN_MS = 15;
    localparam int TIMEOUT_CYC = int'((TIMEOUT_MIN_MS * 64'd1000000000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX   = 5'b00010,
        ST_ACK  = 5'b00100,
        ST_TX   = 5'b01000,
        ST_MACK = 5'b10000
    } otlvc_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_CMD  = 2'h1,
        PH_DATA = 2'h2
    } otlvc_phase_t;
endpackage

// ==== hw/otlvc_top.sv ====
// How it works
// R1 - All configuration reaches the block only through the serial management bus slave.
// R2 - Pin 9 can be set to an alert output for out-of-limit temperatures.
// R3 - Bus clock low past the timeout abandons the transfer; a bit disables it.
// R4 - Pin 5 defaults to fan drive two on base, latch output on latch.
// R5 - Base answers on a fixed address; latch variant address comes from straps.
// R6 - Remote 2 limit defaults to 100 C base, 136 C latch variant.
// R7 - Registers variant_default_reg_a0 to variant_default_reg_a2 reset to 0x00 base, 0xFF latch variant.
// R8 - Writing 1 to bit 7 of config_one_latch_reset resets the latch; lock blocks it.
// R9 - Bit 0 of status_latch_flag reads 1 while an over-temperature event is latched.
// R10 - Registers variant_default_reg_b0 to variant_default_reg_b2 reset to 0x82 base, 0x62 latch variant.
// R11 - Bit 4 of config_hysteresis_ctrl enables hysteresis on the over-temperature output.
// R12 - Bit 4 of config_latch_source: 0 latches on remote 2, 1 on either.
// R13 - Latch and status stay set until the host resets them, despite cooling.
`timescale 1ns/1ps
module otlvc_top
    import otlvc_pkg::*;
#(
    parameter bit LATCH_VARIANT  = 1'b1,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)(
    input  wire logic       CLK_SYS_I,       // System clock, 250 MHz
    input  wire logic       RESET_I,         // Synchronous reset, active high
    input  wire logic       CE_I,            // Clock enable, freezes all state when low
    input  wire logic       SCL_I,           // Bus clock pin
    input  wire logic       SDA_I,           // Bus data pin level
    output logic            SDA_O,           // Bus data drive value, always low
    output logic            SDA_OE_O,        // Bus data output enable
    input  wire logic       ADDREN_I,        // Address mode strap
    input  wire logic       ADDR_SEL_I,      // Address select strap
    input  wire logic [7:0] REMOTE1_TEMP_I,  // Remote channel 1 temperature
    input  wire logic [7:0] REMOTE2_TEMP_I,  // Remote channel 2 temperature
    input  wire logic       FAN_DRIVE_TWO_I, // Fan drive two from fan logic
    output logic            PIN5_O,          // Pin 5 level
    output logic            PIN9_O,          // Pin 9 drive value, always low
    output logic            PIN9_OE_O        // Pin 9 output enable
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] scl_sync_r, sda_sync_r, aen_sync_r, asel_sync_r;
    logic       scl_r, sda_r, scl_d_r, sda_d_r;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            scl_sync_r  <= 3'h7;
            sda_sync_r  <= 3'h7;
            aen_sync_r  <= 3'h7;
            asel_sync_r <= 3'h0;
        end
        else if (CE_I)
        begin
            scl_sync_r  <= {scl_sync_r[1:0], SCL_I};
            sda_sync_r  <= {sda_sync_r[1:0], SDA_I};
            aen_sync_r  <= {aen_sync_r[1:0], ADDREN_I};
            asel_sync_r <= {asel_sync_r[1:0], ADDR_SEL_I};
        end
    end

    // A change counts only once stages two and three agree
    wire scl_agree = scl_sync_r[1] == scl_sync_r[2];
    wire sda_agree = sda_sync_r[1] == sda_sync_r[2];

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            scl_r   <= 1'b1;
            sda_r   <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (CE_I)
        begin
            scl_r   <= scl_agree ? scl_sync_r[2] : scl_r;
            sda_r   <= sda_agree ? sda_sync_r[2] : sda_r;
            scl_d_r <= scl_r;
            sda_d_r <= sda_r;
        end
    end

    wire scl_rise = scl_r & ~scl_d_r;
    wire scl_fall = ~scl_r & scl_d_r;
    wire start_ev = scl_r & scl_d_r & sda_d_r & ~sda_r;
    wire stop_ev  = scl_r & scl_d_r & ~sda_d_r & sda_r;

    // ****************************************************************
    // Address strap capture
    // ****************************************************************
    logic [1:0] strap_cnt_r;
    logic       strap_done_r;
    logic [6:0] slave_addr_r;
    wire  [6:0] strap_addr = aen_sync_r[2] ? ADDR_FIXED
                           : (asel_sync_r[2] ? ADDR_SEL1 : ADDR_SEL0);

    // Straps are caught after release so the synchronisers hold real pin levels
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
            slave_addr_r <= ADDR_FIXED;
        end
        else if (CE_I && strap_cnt_r != STRAP_WAIT)
            strap_cnt_r  <= strap_cnt_r + 2'h1;
        else if (CE_I && !strap_done_r)
        begin
            // Stage three holds the real strap level only from here on
            strap_done_r <= 1'b1;
            slave_addr_r <= LATCH_VARIANT ? strap_addr : ADDR_FIXED; // R5
        end
    end

    // ****************************************************************
    // Clock-low timeout
    // ****************************************************************
    logic [31:0] low_cnt_r;
    logic [7:0]  cfg3_r;
    wire         to_hit = (low_cnt_r == 32'(TIMEOUT_CYCLES)) & ~cfg3_r[BIT_TO_DIS]; // R3

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I || (CE_I && scl_r))
            low_cnt_r <= 32'h0;
        else if (CE_I && low_cnt_r != 32'(TIMEOUT_CYCLES))
            low_cnt_r <= low_cnt_r + 32'h1;
    end

    // ****************************************************************
    // Bus slave state machine
    // ****************************************************************
    otlvc_state_t state_r, state_nxt;
    otlvc_phase_t phase_r, phase_nxt;
    logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic       rw_r, rw_nxt, oe_r, oe_nxt, wr_stb_nxt, wr_stb_r;
    logic [7:0] wr_data_r, rdata;

    always_comb
    begin
        state_nxt  = state_r;
        phase_nxt  = phase_r;
        shift_nxt  = shift_r;
        ptr_nxt    = ptr_r;
        cnt_nxt    = cnt_r;
        rw_nxt     = rw_r;
        oe_nxt     = oe_r;
        wr_stb_nxt = 1'b0;
        if (stop_ev || to_hit)
        begin
            state_nxt = ST_IDLE; // R3
            oe_nxt    = 1'b0;
        end
        else if (start_ev)
        begin
            state_nxt = ST_RX;
            phase_nxt = PH_ADDR;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
        end
        else
        begin
            case (state_r)
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_r};
                        cnt_nxt   = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == BITS_BYTE)
                    begin
                        state_nxt = ST_ACK;
                        oe_nxt    = 1'b1;
                        cnt_nxt   = 4'h0;
                        if (phase_r == PH_ADDR)
                        begin
                            rw_nxt = shift_r[0];
                            if (shift_r[7:1] != slave_addr_r)
                            begin
                                state_nxt = ST_IDLE; // R5
                                oe_nxt    = 1'b0;
                            end
                        end
                        else if (phase_r == PH_CMD)
                            ptr_nxt = shift_r;
                        else
                            wr_stb_nxt = 1'b1; // R1
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (phase_r == PH_ADDR && rw_r)
                        begin
                            state_nxt = ST_TX;
                            shift_nxt = rdata;
                            oe_nxt    = ~rdata[7];
                        end
                        else
                        begin
                            state_nxt = ST_RX;
                            oe_nxt    = 1'b0;
                            phase_nxt = (phase_r == PH_ADDR) ? PH_CMD : PH_DATA;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                        cnt_nxt = cnt_r + 4'h1;
                    else if (scl_fall)
                    begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_nxt    = (cnt_r == BITS_BYTE) ? 1'b0 : ~shift_r[6];
                        state_nxt = (cnt_r == BITS_BYTE) ? ST_MACK : ST_TX;
                    end
                end
                ST_MACK:
                begin
                    // A not-acknowledge ends the read; an acknowledge repeats it
                    if (scl_rise)
                        state_nxt = sda_r ? ST_IDLE : ST_MACK;
                    else if (scl_fall)
                    begin
                        state_nxt = ST_TX;
                        cnt_nxt   = 4'h0;
                        shift_nxt = rdata;
                        oe_nxt    = ~rdata[7];
                    end
                end
                default:
                    oe_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            state_r   <= ST_IDLE;
            phase_r   <= PH_ADDR;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            cnt_r     <= 4'h0;
            rw_r      <= 1'b0;
            oe_r      <= 1'b0;
            wr_stb_r  <= 1'b0;
            wr_data_r <= 8'h00;
        end
        else if (CE_I)
        begin
            state_r   <= state_nxt;
            phase_r   <= phase_nxt;
            shift_r   <= shift_nxt;
            ptr_r     <= ptr_nxt;
            cnt_r     <= cnt_nxt;
            rw_r      <= rw_nxt;
            oe_r      <= oe_nxt;
            wr_stb_r  <= wr_stb_nxt;
            wr_data_r <= shift_r;
        end
    end

    // ****************************************************************
    // Register bank
    // ****************************************************************
    localparam logic [7:0] RST_A  = LATCH_VARIANT ? RST_DEF_A_LATCH : RST_DEF_A_BASE;
    localparam logic [7:0] RST_B  = LATCH_VARIANT ? RST_DEF_B_LATCH : RST_DEF_B_BASE;
    localparam logic [7:0] RST_L2 = LATCH_VARIANT ? RST_LIM_R2_LATCH : RST_LIM_R2_BASE;

    logic [7:0] def_a_r [3];
    logic [7:0] def_b_r [3];
    logic [7:0] cfg1_r, cfg4_r, lim1_r, lim2_r;
    logic       latched_r, ot_r;

    wire sel_a0  = ptr_r == OFS_DEF_A0;
    wire sel_a1  = ptr_r == OFS_DEF_A1;
    wire sel_a2  = ptr_r == OFS_DEF_A2;
    wire sel_b0  = ptr_r == OFS_DEF_B0;
    wire sel_b1  = ptr_r == OFS_DEF_B1;
    wire sel_b2  = ptr_r == OFS_DEF_B2;
    wire sel_c1  = ptr_r == OFS_CONFIG1;
    wire sel_c3  = ptr_r == OFS_CONFIG3;
    wire sel_c4  = ptr_r == OFS_CONFIG4;
    wire sel_l1  = ptr_r == OFS_LIMIT_R1;
    wire sel_l2  = ptr_r == OFS_LIMIT_R2;
    wire sel_st  = ptr_r == OFS_STATUS;
    wire sel_rev = ptr_r == OFS_REVISION;
    wire locked  = cfg1_r[BIT_LOCK];

    // Lock freezes configuration until reset, the latch reset bit included
    wire wr_ok       = wr_stb_r & ~locked;
    wire latch_clear = LATCH_VARIANT & wr_ok & sel_c1 & wr_data_r[BIT_LATCH_RESET]; // R8

    // Reserved bits on the base variant never store and read as zero
    wire [7:0] c1_mask = LATCH_VARIANT ? 8'h7F : 8'h7F;
    wire [7:0] c3_mask = LATCH_VARIANT ? 8'hFF : ~(8'h01 << BIT_HYST_EN);
    wire [7:0] c4_mask = LATCH_VARIANT ? 8'hFF : ~(8'h01 << BIT_LATCH_SRC);

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            def_a_r <= '{RST_A, RST_A, RST_A}; // R7
            def_b_r <= '{RST_B, RST_B, RST_B}; // R10
            cfg1_r  <= RST_CONFIG;
            cfg3_r  <= RST_CONFIG;
            cfg4_r  <= RST_CONFIG | (LATCH_VARIANT ? 8'h00 : (8'h01 << BIT_PIN5_FAN)); // R4
            lim1_r  <= RST_LIM_R1;
            lim2_r  <= RST_L2; // R6
        end
        else if (CE_I && wr_ok)
        begin
            if (sel_a0) def_a_r[0] <= wr_data_r;
            if (sel_a1) def_a_r[1] <= wr_data_r;
            if (sel_a2) def_a_r[2] <= wr_data_r;
            if (sel_b0) def_b_r[0] <= wr_data_r;
            if (sel_b1) def_b_r[1] <= wr_data_r;
            if (sel_b2) def_b_r[2] <= wr_data_r;
            if (sel_c1) cfg1_r <= wr_data_r & c1_mask;
            if (sel_c3) cfg3_r <= wr_data_r & c3_mask; // R11
            if (sel_c4) cfg4_r <= wr_data_r & c4_mask; // R12
            if (sel_l1) lim1_r <= wr_data_r;
            if (sel_l2) lim2_r <= wr_data_r;
        end
    end

    assign rdata = sel_a0  ? def_a_r[0]
                 : sel_a1  ? def_a_r[1]
                 : sel_a2  ? def_a_r[2]
                 : sel_b0  ? def_b_r[0]
                 : sel_b1  ? def_b_r[1]
                 : sel_b2  ? def_b_r[2]
                 : sel_c1  ? cfg1_r
                 : sel_c3  ? cfg3_r
                 : sel_c4  ? cfg4_r
                 : sel_l1  ? lim1_r
                 : sel_l2  ? lim2_r
                 : sel_st  ? {7'h00, latched_r & LATCH_VARIANT} // R9
                 : sel_rev ? (LATCH_VARIANT ? REV_LATCH : REV_BASE)
                 : 8'h00;

    // ****************************************************************
    // Over-temperature detection and latch
    // ****************************************************************
    wire over1 = REMOTE1_TEMP_I > lim1_r;
    wire over2 = REMOTE2_TEMP_I > lim2_r;
    wire hyst  = cfg3_r[BIT_HYST_EN];
    wire below = (REMOTE1_TEMP_I <= lim1_r - (hyst ? HYST_DEGREES : 8'h00))
               & (REMOTE2_TEMP_I <= lim2_r - (hyst ? HYST_DEGREES : 8'h00));
    wire latch_src = cfg4_r[BIT_LATCH_SRC] ? (over1 | over2) : over2; // R12

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            latched_r <= 1'b0;
            ot_r      <= 1'b0;
        end
        else if (CE_I)
        begin
            // A new event in the clearing cycle keeps the latch set
            latched_r <= latch_src | (latched_r & ~latch_clear); // R13
            ot_r      <= (over1 | over2) | (ot_r & ~below); // R11
        end
    end

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    wire [1:0] pin9_mode = {cfg4_r[BIT_PIN9_HI], cfg4_r[BIT_PIN9_LO]};
    wire       alert     = over1 | over2 | latched_r;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            SDA_O     <= 1'b0;
            SDA_OE_O  <= 1'b0;
            PIN5_O    <= 1'b0;
            PIN9_O    <= 1'b0;
            PIN9_OE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            SDA_OE_O  <= oe_r;
            PIN5_O    <= cfg4_r[BIT_PIN5_FAN] ? FAN_DRIVE_TWO_I : latched_r; // R4
            PIN9_OE_O <= ((pin9_mode == PIN9_ALERT) & alert) // R2
                       | ((pin9_mode == PIN9_THERM) & ot_r);
        end
    end

endmodule

// ==== bench/otlvc_monitor.sv ====
`timescale 1ns/1ps
module otlvc_monitor
    import otlvc_pkg::*;
#(
    parameter bit LATCH_VARIANT  = 1'b1,
    parameter int TIMEOUT_CYCLES = 200
)(
    input wire logic       CLK_SYS_I,      // System clock
    input wire logic       RESET_I,        // Synchronous reset
    input wire logic       SCL_I,          // Bus clock pin
    input wire logic       SDA_O,          // Data drive value
    input wire logic       SDA_OE_O,       // Data pull-down enable
    input wire logic [7:0] REMOTE1_TEMP_I, // Remote 1 temperature
    input wire logic [7:0] REMOTE2_TEMP_I, // Remote 2 temperature
    input wire logic       PIN5_O,         // Pin 5 level
    input wire logic       PIN9_O,         // Pin 9 drive value
    input wire logic       PIN9_OE_O       // Pin 9 pull-down enable
);
    // ********************
    // Helpers: limits are taken at their defaults, which the bench never rewrites
    // ********************
    logic [7:0]  lim2;
    logic        hot;
    logic [2:0]  hot_r;
    logic [31:0] low_cnt_r;
    logic [4:0]  high_cnt_r;
    logic [4:0]  high_cnt_nxt;
    assign lim2         = LATCH_VARIANT ? RST_LIM_R2_LATCH : RST_LIM_R2_BASE;
    assign hot          = (REMOTE1_TEMP_I > RST_LIM_R1) || (REMOTE2_TEMP_I > lim2);
    assign high_cnt_nxt = (!SCL_I) ? 5'h00 : high_cnt_r + {4'h0, ~&high_cnt_r};
    always_ff @(posedge CLK_SYS_I)
    begin
        hot_r      <= {hot_r[1:0], hot};
        low_cnt_r  <= SCL_I ? 32'h0 : low_cnt_r + 32'h1;
        high_cnt_r <= RESET_I ? 5'h00 : high_cnt_nxt;
    end
    // ********************
    // Properties
    // ********************
    default clocking mon_cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    chk_sda_open_drain: assert property (SDA_O == 1'b0)
        else $error("data line driven high");
    chk_drive_in_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("data line changed while bus clock high");
    chk_pin9_open_drain: assert property (PIN9_O == 1'b0)
        else $error("pin 9 driven high");
    chk_alert_cause: assert property ($rose(PIN9_OE_O) |-> (hot || (|hot_r) || PIN5_O))
        else $error("pin 9 asserted with nothing over its limit");
    chk_timeout_release: assert property ((low_cnt_r > TIMEOUT_CYCLES + 16) |-> !SDA_OE_O)
        else $error("data line still held after clock low timeout");
    chk_hot_sets_pin5: assert property ((LATCH_VARIANT && (REMOTE2_TEMP_I > lim2)) |-> ##2 PIN5_O)
        else $error("hot remote 2 did not raise the latch output");
    chk_pin5_cause: assert property ((LATCH_VARIANT && $rose(PIN5_O)) |-> $past(hot, 2))
        else $error("latch output rose without a hot channel");
    chk_latch_holds: assert property ((LATCH_VARIANT && high_cnt_r[4] && PIN5_O) |=> PIN5_O)
        else $error("latch output dropped with the bus idle");
endmodule

// ==== bench/otlvc_host.sv ====
`timescale 1ns/1ps
module otlvc_host (
    input  wire logic clk_i,    // Bench clock
    input  wire logic sda_i,    // Resolved data line
    output logic      scl_o,    // Bus clock, high outside frames
    output logic      sda_low_o // Host pulls data low
);
    // ********************
    // Bus host: ten clocks per third of a bit so the slave's input filters keep up
    // ********************
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic bit_io(input logic b, output logic s);
        sda_low_o <= ~b;
        repeat (10) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        s = sda_i;
        scl_o <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic start;
        sda_low_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        scl_o <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic stop;
        sda_low_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        sda_low_o <= 1'b0;
        repeat (20) @(posedge clk_i);
    endtask
    task automatic send(input logic [7:0] b, output logic ok);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ok = ~s;
    endtask
    task automatic recv(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(1'b1, s); // Not acknowledged: reads are one byte long
    endtask
    // Reads set the pointer first, then stop and start again in read direction
    task automatic access(input logic [6:0] dev, input logic [7:0] ofs, input logic wr,
                          input logic [7:0] wdat, output logic [7:0] rdat, output logic ok);
        logic [2:0] a;
        start();
        send({dev, 1'b0}, a[0]);
        send(ofs, a[1]);
        if (wr)
            send(wdat, a[2]);
        else
        begin
            stop();
            start();
            send({dev, 1'b1}, a[2]);
            recv(rdat);
        end
        stop();
        ok = &a;
    endtask
endmodule

// ==== bench/otlvc_bench.sv ====
`timescale 1ns/1ps
module otlvc_bench
    import otlvc_pkg::*;
;
    localparam logic [6:0] DEV = ADDR_SEL1; // Select mode with select strap high
    logic       clk, rst, fan, scl, host_low, sda_oe, sda, pin5, pin9_oe, ack;
    logic [7:0] r1, r2, d, wd;
    int         n_fail, checks, seed;
    logic [7:0] ofs_list [9] = '{8'h30, 8'h31, 8'h32, 8'h3F, 8'h5C, 8'h5D, 8'h5E, 8'h6B, 8'hA0};
    logic [7:0] exp_list [9] = '{8'hFF, 8'hFF, 8'hFF, REV_LATCH, 8'h62, 8'h62, 8'h62, 8'h88, 8'h00};
    otlvc_top #(.LATCH_VARIANT(1'b1), .TIMEOUT_CYCLES(200)) uut (
        .CLK_SYS_I(clk), .RESET_I(rst), .CE_I(1'b1), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(), .SDA_OE_O(sda_oe), .ADDREN_I(1'b0), .ADDR_SEL_I(1'b1),
        .REMOTE1_TEMP_I(r1), .REMOTE2_TEMP_I(r2), .FAN_DRIVE_TWO_I(fan),
        .PIN5_O(pin5), .PIN9_O(), .PIN9_OE_O(pin9_oe));
    otlvc_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    assign sda = ~(host_low | sda_oe); // Pull-up wins when nobody pulls low
    // ********************
    // Helpers
    // ********************
    function automatic logic [7:0] heat(input logic [7:0] lim, input logic on);
        return on ? 8'(lim + 1 + $urandom_range(254 - lim)) : 8'($urandom_range(lim));
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) fan <= 1'($urandom);
    initial
    begin
        repeat (80000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    // ********************
    // Main sequence
    // ********************
    initial
    begin
        seed   = $urandom(24260);
        rst    = 1'b1;
        r1     = 8'h00;
        r2     = 8'h00;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        host.access(DEV, 8'hA0, 1'b1, 8'($urandom), d, ack);
        foreach (ofs_list[i])
        begin
            host.access(DEV, ofs_list[i], 1'b0, 8'h00, d, ack);
            check("reset value", d, exp_list[i]);
        end
        wd = 8'($urandom);
        host.access(DEV, OFS_DEF_A1, 1'b1, wd, d, ack);
        check("device ack", ack, 1'b1);
        host.access(DEV, OFS_DEF_A1, 1'b0, 8'h00, d, ack);
        check("written value", d, wd);
        host.access(ADDR_FIXED, OFS_DEF_A0, 1'b0, 8'h00, d, ack);
        check("foreign address ack", ack, 1'b0);
        r2 <= heat(RST_LIM_R2_LATCH, 1'b1);
        repeat (4) @(posedge clk);
        check("latch output", pin5, 1'b1);
        r2 <= heat(RST_LIM_R2_LATCH, 1'b0);
        repeat (40) @(posedge clk);
        check("latch held", pin5, 1'b1);
        host.access(DEV, OFS_STATUS, 1'b0, 8'h00, d, ack);
        check("latched flag", d[0], 1'b1);
        host.access(DEV, OFS_CONFIG1, 1'b1, 8'h80, d, ack);
        check("latch cleared", pin5, 1'b0);
        host.access(DEV, OFS_STATUS, 1'b0, 8'h00, d, ack);
        check("flag cleared", d[0], 1'b0);
        r1 <= heat(RST_LIM_R1, 1'b1);
        repeat (10) @(posedge clk);
        check("remote one ignored", pin5, 1'b0);
        host.access(DEV, OFS_CONFIG4, 1'b1, 8'h13, d, ack);
        check("remote one latched", pin5, 1'b1);
        check("alert output", pin9_oe, 1'b1);
        r1 <= heat(RST_LIM_R1, 1'b0);
        host.access(DEV, OFS_CONFIG1, 1'b1, 8'h80, d, ack);
        check("alert released", pin9_oe, 1'b0);
        // Stall with the clock low while the slave drives a zero data bit
        host.access(DEV, OFS_DEF_B0, 1'b0, 8'h00, d, ack);
        host.start();
        host.send({DEV, 1'b1}, ack);
        repeat (60) @(posedge clk);
        check("data bit driven", sda_oe, 1'b1);
        repeat (200) @(posedge clk);
        check("timeout release", sda_oe, 1'b0);
        host.stop();
        host.access(DEV, OFS_CONFIG1, 1'b1, 8'h02, d, ack);
        r2 <= heat(RST_LIM_R2_LATCH, 1'b1);
        repeat (4) @(posedge clk);
        r2 <= heat(RST_LIM_R2_LATCH, 1'b0);
        host.access(DEV, OFS_CONFIG1, 1'b1, 8'h80, d, ack);
        check("locked latch", pin5, 1'b1);
        host.access(DEV, OFS_DEF_A0, 1'b1, 8'h00, d, ack);
        host.access(DEV, OFS_DEF_A0, 1'b0, 8'h00, d, ack);
        check("locked register", d, RST_DEF_A_LATCH);
        end_of_test();
    end
endmodule
bind otlvc_top otlvc_monitor #(.LATCH_VARIANT(LATCH_VARIANT), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .REMOTE1_TEMP_I(REMOTE1_TEMP_I), .REMOTE2_TEMP_I(REMOTE2_TEMP_I), .PIN5_O(PIN5_O),
    .PIN9_O(PIN9_O), .PIN9_OE_O(PIN9_OE_O));
